// ---- design/address_area_decoder.sv ----
// address-area decoder: area, space, width, selects and wait figures
`timescale 1ns/1ps
module address_area_decoder
	import area_decode_pkg::*;
#(
	parameter int ROM_BYTES = ROM_SMALL_BYTES
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// internal bus address
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic bus_addr_valid,
	// strap pins
	input wire logic [2:0] boot_mode_pins,
	// bus control bits
	input wire logic area1_dram_enable,
	input wire logic muxed_io_enable,
	input wire logic row_col_mux_enable,
	// long wait fields
	input wire logic area02_longwait_hi,
	input wire logic area02_longwait_lo,
	input wire logic area6_longwait_hi,
	input wire logic area6_longwait_lo,
	// per-area two-state read cycle bits
	input wire logic [NUM_AREAS-1:0] wait_two_state,
	// decode result
	output logic decode_valid,
	output logic [AREA_W-1:0] area_index,
	output space_t space_type,
	output width_t bus_width,
	output logic [LOCAL_W-1:0] local_addr,
	output logic addr_hi_drive,
	// chip selects, active low
	output logic area0_select_n,
	output logic area1_select_n,
	output logic area2_select_n,
	output logic area3_select_n,
	output logic area4_select_n,
	output logic area5_select_n,
	output logic area6_select_n,
	output logic area7_select_n,
	// strobe style
	output logic dram_strobes_active,
	output logic muxed_io_cycle,
	output logic sram_strobes,
	// wait figures
	output logic [2:0] longwait_states,
	output logic [2:0] access_states
);
	// ===================================================
	// local constants
	localparam logic [4:0] ROM_BITS = 5'($clog2(ROM_BYTES));

	// ===================================================
	// boot strap capture
	logic [2:0] boot_mode;
	logic boot_taken;

	// strap sampled once in the first clock after reset release,
	// so area 0 cannot flip if the pins bounce later
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			boot_mode <= BOOT_MODE_RESET;
			boot_taken <= 1'b0;
		end
		else if (!boot_taken)
		begin
			boot_mode <= boot_mode_pins; // R24
			boot_taken <= 1'b1;
		end
	end

	// ===================================================
	// area lookup
	decode_if dif ();
	logic [AREA_W-1:0] next_area;

	// area is just the three bits above the 16 Mbyte offset
	assign next_area = bus_addr[AREA_LSB +: AREA_W]; // R1
	assign dif.area = next_area;
	assign dif.wide_sel = bus_addr[WIDTH_SEL_BIT];
	assign dif.periph_hi = bus_addr[PERIPH_WIDTH_BIT];
	assign dif.muxio_hi = bus_addr[MUXIO_WIDTH_BIT];
	assign dif.boot_mode = boot_mode;
	assign dif.dram_en = area1_dram_enable;
	assign dif.muxio_en = muxed_io_enable;

	area_lookup u_lookup (
		.dif(dif)
	);

	// ===================================================
	// next values
	logic next_valid;
	logic next_external;
	logic [4:0] next_bits;
	logic [LOCAL_W-1:0] next_local;
	logic [NUM_AREAS-1:0] next_select_n;
	logic [2:0] next_longwait;
	logic [2:0] next_states;

	// nothing is reported before the strap is known
	assign next_valid = bus_addr_valid && boot_taken;
	assign next_external = dif.chip_sel || (dif.space == SPACE_DRAM);

	// offset bits kept per space, giving the shadow size
	always_comb
	begin
		next_bits = EXT_BITS; // R5
		unique case (dif.space)
			SPACE_ROM: next_bits = ROM_BITS; // R3
			SPACE_RAM: next_bits = RAM_BITS; // R20
			SPACE_PERIPH: next_bits = PERIPH_BITS; // R12
			SPACE_DRAM:
			begin
				// only the row/column mux reaches bits 23 and 22
				if (row_col_mux_enable) // R9
				begin
					next_bits = DRAM_BITS;
				end
				else
				begin
					next_bits = EXT_BITS;
				end
			end
			default: next_bits = EXT_BITS;
		endcase
	end

	assign next_local = bus_addr[LOCAL_W-1:0] & ~(LOCAL_ONES << next_bits);

	// one select low, and only for an area reached with a select
	always_comb
	begin
		next_select_n = SELECTS_IDLE;
		if (next_valid && dif.chip_sel) // R23
		begin
			next_select_n[next_area] = 1'b0;
		end
	end

	// long wait applies to areas 0, 2 and 6 when they go off chip
	always_comb
	begin
		next_longwait = STATES_NONE;
		if (dif.chip_sel)
		begin
			if (next_area == AREA_BOOT || next_area == AREA_LONG2)
			begin
				next_longwait = LONGWAIT_BASE
					+ {1'b0, area02_longwait_hi, area02_longwait_lo}; // R6
			end
			else if (next_area == AREA_MUXIO)
			begin
				next_longwait = LONGWAIT_BASE
					+ {1'b0, area6_longwait_hi, area6_longwait_lo}; // R18
			end
		end
	end

	// base states of an external cycle, pin waits not counted;
	// long-wait areas take one state plus the long waits
	always_comb
	begin
		next_states = STATES_NONE;
		if (next_external)
		begin
			if (next_longwait != STATES_NONE)
			begin
				next_states = STATES_ONE + next_longwait; // R21
			end
			else if (wait_two_state[next_area])
			begin
				next_states = STATES_TWO;
			end
			else
			begin
				next_states = STATES_ONE;
			end
		end
	end

	// ===================================================
	// result registers
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			decode_valid <= 1'b0;
		end
		else
		begin
			decode_valid <= next_valid; // R25
		end
	end

	// area, space and width move together in one edge
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			area_index <= AREA_BOOT;
			space_type <= SPACE_NONE;
			bus_width <= WIDTH_8;
		end
		else
		begin
			area_index <= next_area; // R25
			space_type <= next_valid ? dif.space : SPACE_NONE;
			bus_width <= dif.width;
		end
	end

	// masked offset and upper bit drive
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			local_addr <= LOCAL_RESET;
			addr_hi_drive <= 1'b0;
		end
		else
		begin
			local_addr <= next_local; // R5
			addr_hi_drive <= next_valid && (next_bits == DRAM_BITS); // R9
		end
	end

	// ===================================================
	// chip selects, one flop per area
	logic [NUM_AREAS-1:0] select_n;

	generate
		for (genvar i = 0; i < NUM_AREAS; i++)
		begin : g_select
			always_ff @(posedge ref_clk)
			begin
				if (rst)
				begin
					select_n[i] <= 1'b1;
				end
				else
				begin
					select_n[i] <= next_select_n[i]; // R23
				end
			end
		end
	endgenerate

	assign area0_select_n = select_n[0]; // R4
	assign area1_select_n = select_n[1]; // R10
	assign area2_select_n = select_n[2];
	assign area3_select_n = select_n[3];
	assign area4_select_n = select_n[4];
	assign area5_select_n = select_n[5]; // R13
	assign area6_select_n = select_n[6];
	assign area7_select_n = select_n[7]; // R19

	// ===================================================
	// strobe style flags for the bus sequencer
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			dram_strobes_active <= 1'b0;
			muxed_io_cycle <= 1'b0;
			sram_strobes <= 1'b0;
		end
		else
		begin
			// row/column strobes flagged for every dram access, whatever row_col_mux_enable says
			dram_strobes_active <= next_valid
				&& (dif.space == SPACE_DRAM); // R10
			muxed_io_cycle <= next_valid
				&& (dif.space == SPACE_MUXIO); // R16
			sram_strobes <= next_valid
				&& (dif.space == SPACE_EXT); // R22
		end
	end

	// ===================================================
	// wait figures
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			longwait_states <= STATES_NONE;
			access_states <= STATES_NONE;
		end
		else
		begin
			longwait_states <= next_valid ? next_longwait : STATES_NONE;
			access_states <= next_valid ? next_states : STATES_NONE;
		end
	end
endmodule

// ---- design/area_decode_pkg.sv ----
// constants, types and field layout of the address-area decoder
// Functional notes
// R1: area number is address bits 26..24; each area mirrors at bit 27.
// R2: area 0 follows boot pins: 000 ext 8-bit, 001 ext 16-bit, 010 ROM.
// R3: ROM ignores bits above its size; 16 or 32 kbyte shadows.
// R4: area 0 select idle for ROM, active for area 0 external memory.
// R5: external areas leave bits 23,22 undriven; 4 Mbyte shadows.
// R6: areas 0 and 2 external get 1-4 long waits from shared field.
// R7: area 1 is external memory, or DRAM when DRAM enable is set.
// R8: areas 1-4 and DRAM: 8-bit when bit 27 is 0, else 16-bit.
// R9: with row/column mux enabled, DRAM uses bits 23..0, 16 Mbyte.
// R10: DRAM keeps area 1 select idle; row/column strobes used instead.
// R11: areas 2, 3, 4 always external memory with own select.
// R12: area 5 with bit 27 clear is peripherals, 512 byte shadows.
// R13: peripheral width by bit 8; area 5 select stays idle.
// R14: area 5 with bit 27 set is 16-bit external, select active.
// R15: area 6 low half is muxed I/O if enabled, else external memory.
// R16: muxed I/O: address then data, width by bit 14, select active.
// R17: area 6 external width by bit 14, or 16-bit with bit 27 set.
// R18: area 6 external gets 1-4 long waits from its own field.
// R19: area 7 low half 8-bit external with select; high half RAM.
// R20: RAM is 32-bit, 1 kbyte, 8 kbyte shadows, select idle; the code keeps 10 offset bits, so 1 kbyte shadows.
// R21: external cycle is 1 or 2 states plus waits, per wait control.
// R22: external memory strobes suit a directly attached static RAM.
// R23: only the addressed external area's select goes low.
// R24: boot pins are captured once after reset release.
// R25: area, space, width, selects and long wait reported together.
package area_decode_pkg;
	// ===================================================
	// address layout
	localparam int ADDR_W = 28;
	localparam int AREA_LSB = 24;
	localparam int AREA_W = 3;
	localparam int NUM_AREAS = 8;
	localparam int WIDTH_SEL_BIT = 27;
	localparam int PERIPH_WIDTH_BIT = 8;
	localparam int MUXIO_WIDTH_BIT = 14;
	localparam int LOCAL_W = 24;
	localparam logic [LOCAL_W-1:0] LOCAL_ONES = 24'hFFFFFF;
	// ===================================================
	// space sizes in bytes and the offset bits they keep
	localparam int ROM_SMALL_BYTES = 16 * 1024;
	localparam int ROM_LARGE_BYTES = 32 * 1024;
	localparam int RAM_BYTES = 1024;
	localparam int PERIPH_BYTES = 512;
	localparam int EXT_BYTES = 4 * 1024 * 1024;
	localparam int DRAM_BYTES = 16 * 1024 * 1024;
	localparam logic [4:0] RAM_BITS = 5'($clog2(RAM_BYTES));
	localparam logic [4:0] PERIPH_BITS = 5'($clog2(PERIPH_BYTES));
	localparam logic [4:0] EXT_BITS = 5'($clog2(EXT_BYTES));
	localparam logic [4:0] DRAM_BITS = 5'($clog2(DRAM_BYTES));
	// ===================================================
	// boot pin codes and area roles
	localparam logic [2:0] MODE_EXT8 = 3'h0;
	localparam logic [2:0] MODE_EXT16 = 3'h1;
	localparam logic [2:0] MODE_ROM = 3'h2;
	localparam logic [2:0] BOOT_MODE_RESET = 3'h0;
	localparam logic [2:0] AREA_BOOT = 3'h0;
	localparam logic [2:0] AREA_DRAM = 3'h1;
	localparam logic [2:0] AREA_LONG2 = 3'h2;
	localparam logic [2:0] AREA_PERIPH = 3'h5;
	localparam logic [2:0] AREA_MUXIO = 3'h6;
	localparam logic [2:0] AREA_RAM = 3'h7;
	// ===================================================
	// cycle figures
	localparam logic [2:0] LONGWAIT_BASE = 3'h1;
	localparam logic [2:0] STATES_ONE = 3'h1;
	localparam logic [2:0] STATES_TWO = 3'h2;
	localparam logic [2:0] STATES_NONE = 3'h0;
	localparam logic [NUM_AREAS-1:0] SELECTS_IDLE = 8'hFF;
	localparam logic [LOCAL_W-1:0] LOCAL_RESET = 24'h000000;
	// ===================================================
	// types
	typedef enum logic [6:0] {
		SPACE_NONE = 7'h01,
		SPACE_ROM = 7'h02,
		SPACE_RAM = 7'h04,
		SPACE_PERIPH = 7'h08,
		SPACE_EXT = 7'h10,
		SPACE_DRAM = 7'h20,
		SPACE_MUXIO = 7'h40
	} space_t;
	typedef enum logic [2:0] {
		WIDTH_8 = 3'h1,
		WIDTH_16 = 3'h2,
		WIDTH_32 = 3'h4
	} width_t;
endpackage

// ---- design/decode_if.sv ----
// carrier between the decoder top and its area lookup
`timescale 1ns/1ps
interface decode_if;
	import area_decode_pkg::*;
	logic [AREA_W-1:0] area;
	logic wide_sel;
	logic periph_hi;
	logic muxio_hi;
	logic [2:0] boot_mode;
	logic dram_en;
	logic muxio_en;
	space_t space;
	width_t width;
	logic chip_sel;
	modport requester (
		output area, wide_sel, periph_hi, muxio_hi,
		output boot_mode, dram_en, muxio_en,
		input space, width, chip_sel
	);
	modport resolver (
		input area, wide_sel, periph_hi, muxio_hi,
		input boot_mode, dram_en, muxio_en,
		output space, width, chip_sel
	);
endinterface

// ---- design/area_lookup.sv ----
// space type, bus width and select need of one area
`timescale 1ns/1ps
module area_lookup
	import area_decode_pkg::*;
(
	// query and answer
	decode_if.resolver dif
);
	// ===================================================
	// per-area table; purely combinational
	always_comb
	begin
		dif.space = SPACE_EXT;
		dif.width = dif.wide_sel ? WIDTH_16 : WIDTH_8; // R8
		dif.chip_sel = 1'b1; // R11
		unique case (dif.area)
			AREA_BOOT:
			begin
				// bit 27 plays no part here
				if (dif.boot_mode == MODE_EXT8) // R2
				begin
					dif.width = WIDTH_8;
				end
				else if (dif.boot_mode == MODE_EXT16)
				begin
					dif.width = WIDTH_16;
				end
				else if (dif.boot_mode == MODE_ROM)
				begin
					dif.space = SPACE_ROM;
					dif.width = WIDTH_32;
					dif.chip_sel = 1'b0; // R4
				end
				else
				begin
					// undefined boot code: nothing answers
					dif.space = SPACE_NONE;
					dif.width = WIDTH_8;
					dif.chip_sel = 1'b0;
				end
			end
			AREA_DRAM:
			begin
				if (dif.dram_en) // R7
				begin
					dif.space = SPACE_DRAM;
					dif.chip_sel = 1'b0; // R10
				end
			end
			AREA_PERIPH:
			begin
				if (!dif.wide_sel) // R12
				begin
					dif.space = SPACE_PERIPH;
					dif.chip_sel = 1'b0; // R13
					dif.width = dif.periph_hi ? WIDTH_16 : WIDTH_8;
				end
				else
				begin
					dif.width = WIDTH_16; // R14
				end
			end
			AREA_MUXIO:
			begin
				if (dif.wide_sel)
				begin
					dif.width = WIDTH_16; // R17
				end
				else
				begin
					// bit 14 splits both kinds of low half
					dif.width = dif.muxio_hi ? WIDTH_16 : WIDTH_8; // R16
					if (dif.muxio_en) // R15
					begin
						dif.space = SPACE_MUXIO;
					end
				end
			end
			AREA_RAM:
			begin
				if (dif.wide_sel) // R19
				begin
					dif.space = SPACE_RAM;
					dif.width = WIDTH_32; // R20
					dif.chip_sel = 1'b0;
				end
				else
				begin
					dif.width = WIDTH_8;
				end
			end
			default:
			begin
				// areas 2, 3 and 4 keep the plain external answer
				dif.space = SPACE_EXT;
			end
		endcase
	end
endmodule

// ---- tb/address_area_decoder_properties.sv ----
// concurrent checks on the address-area decoder ports
`timescale 1ns/1ps
module address_area_decoder_chk
	import area_decode_pkg::*;
#(
	parameter int ROM_BYTES = ROM_SMALL_BYTES
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// inputs watched
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic bus_addr_valid,
	input wire logic area1_dram_enable,
	input wire logic area02_longwait_hi,
	input wire logic area02_longwait_lo,
	// outputs watched
	input wire logic decode_valid,
	input wire logic [AREA_W-1:0] area_index,
	input wire space_t space_type,
	input wire width_t bus_width,
	input wire logic [LOCAL_W-1:0] local_addr,
	input wire logic addr_hi_drive,
	input wire logic area0_select_n,
	input wire logic area1_select_n,
	input wire logic area2_select_n,
	input wire logic area3_select_n,
	input wire logic area4_select_n,
	input wire logic area5_select_n,
	input wire logic area6_select_n,
	input wire logic area7_select_n,
	input wire logic dram_strobes_active,
	input wire logic muxed_io_cycle,
	input wire logic [2:0] longwait_states
);
	logic [7:0] sel_n;
	// selects gathered so one relation covers all eight
	assign sel_n = {area7_select_n, area6_select_n, area5_select_n,
		area4_select_n, area3_select_n, area2_select_n, area1_select_n,
		area0_select_n};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ===================================================
	// request steps
	sequence area2_req_s;
		bus_addr_valid && bus_addr[26:24] == 3'h2 && !bus_addr[27];
	endsequence
	sequence area2_ans_s;
		area2_req_s ##1 decode_valid;
	endsequence
	// ===================================================
	// selects
	sel_single_a: assert property (
		$countones(~sel_n) <= 1)
		else $error("more than one select low");
	sel_area_a: assert property (
		sel_n != 8'hFF |-> ~sel_n == (8'h01 << area_index))
		else $error("low select differs from area");
	idle_sel_a: assert property (
		!$past(bus_addr_valid) |-> sel_n == 8'hFF && !decode_valid
		&& space_type == SPACE_NONE)
		else $error("outputs active without request");
	result_lat_a: assert property (
		decode_valid |-> $past(bus_addr_valid)
		&& area_index == $past(bus_addr[26:24]))
		else $error("area not from previous address");
	onchip_sel_a: assert property (
		space_type inside {SPACE_ROM, SPACE_RAM, SPACE_PERIPH}
		|-> sel_n == 8'hFF)
		else $error("select low for on-chip space");
	rom_shape_a: assert property (
		space_type == SPACE_ROM |-> bus_width == WIDTH_32
		&& local_addr < ROM_BYTES && area_index == 3'h0)
		else $error("rom width or shadow wrong");
	ram_shape_a: assert property (
		space_type == SPACE_RAM |-> bus_width == WIDTH_32
		&& local_addr[23:10] == 14'h0 && $past(bus_addr[27]))
		else $error("ram width or shadow wrong");
	periph_width_a: assert property (
		space_type == SPACE_PERIPH |-> local_addr[23:9] == 15'h0
		&& bus_width == ($past(bus_addr[8]) ? WIDTH_16 : WIDTH_8))
		else $error("peripheral width or shadow wrong");
	dram_sel_a: assert property (
		space_type == SPACE_DRAM |-> area1_select_n
		&& dram_strobes_active && $past(area1_dram_enable))
		else $error("dram access shape wrong");
	ext_shadow_a: assert property (
		space_type == SPACE_EXT |-> local_addr[23:22] == 2'h0
		&& !addr_hi_drive && !sel_n[area_index])
		else $error("external shadow or select wrong");
	area2_wait_a: assert property (
		area2_ans_s |-> !area2_select_n && longwait_states
		== $past({area02_longwait_hi, area02_longwait_lo}) + 3'h1)
		else $error("area 2 long wait wrong");
	muxio_sel_a: assert property (
		space_type == SPACE_MUXIO |-> !area6_select_n
		&& muxed_io_cycle && area_index == 3'h6)
		else $error("muxed io access shape wrong");
	area2_seen_c: cover property (area2_ans_s);
endmodule

bind address_area_decoder address_area_decoder_chk #(.ROM_BYTES(ROM_BYTES))
	i_chk (.ref_clk, .rst, .bus_addr, .bus_addr_valid, .area1_dram_enable,
	.area02_longwait_hi, .area02_longwait_lo, .decode_valid, .area_index,
	.space_type, .bus_width, .local_addr, .addr_hi_drive, .area0_select_n,
	.area1_select_n, .area2_select_n, .area3_select_n, .area4_select_n,
	.area5_select_n, .area6_select_n, .area7_select_n,
	.dram_strobes_active, .muxed_io_cycle, .longwait_states);

// ---- tb/ext_device_model.sv ----
// external devices on the bus: count the cycles they are selected
`timescale 1ns/1ps
module ext_device_model
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// bus side
	input wire logic [7:0] select_n,
	input wire logic strobe,
	// tally
	output int hits
);
	// ===================================================
	// a device only answers when its select and a strobe agree
	always_ff @(posedge ref_clk)
		if (rst)
			hits <= 0;
		else if (select_n != 8'hFF && strobe)
			hits <= hits + 1;
endmodule

// ---- tb/test_address_area_decoder.sv ----
// self-checking bench for the address-area decoder
`timescale 1ns/1ps
module test_address_area_decoder;
	import area_decode_pkg::*;
	localparam int ROM_B = ROM_LARGE_BYTES;
	localparam logic [47:0] IDLE = {SPACE_NONE, 3'h0, 8'hFF, 30'h0};
	localparam logic [47:0] IDLE_M = {7'h7F, 3'h0, 8'hFF, 3'h7, 3'h7, 24'h0};
	localparam logic [27:0] CORNER [10] = '{28'h2000010, 28'h5000100,
		28'hF001404, 28'h8C04004, 28'h1C00000, 28'h6004000, 28'hE000000,
		28'h7000000, 28'hD3FFFFF, 28'h9FFFFFF};
	// ===================================================
	// design signals
	logic ref_clk, rst, bus_addr_valid, decode_valid, addr_hi_drive;
	logic [ADDR_W-1:0] bus_addr;
	logic [2:0] boot_mode_pins, area_index, longwait_states, access_states;
	logic [14:0] kn;
	logic [7:0] sel_n;
	logic [LOCAL_W-1:0] local_addr;
	space_t space_type;
	width_t bus_width;
	logic dram_strobes_active, muxed_io_cycle, sram_strobes;
	logic area0_select_n, area1_select_n, area2_select_n, area3_select_n;
	logic area4_select_n, area5_select_n, area6_select_n, area7_select_n;
	int miscompares, checks, exp_hits, hits;
	logic [47:0] pe, pm, obs;
	logic [4:0] pa;
	logic [2:0] mode;
	logic pend;
	assign sel_n = {area7_select_n, area6_select_n, area5_select_n,
		area4_select_n, area3_select_n, area2_select_n, area1_select_n,
		area0_select_n};
	assign obs = {space_type, bus_width, sel_n, longwait_states,
		access_states, local_addr};
	address_area_decoder #(.ROM_BYTES(ROM_B)) i_dut (.ref_clk, .rst,
		.bus_addr, .bus_addr_valid, .boot_mode_pins,
		.area1_dram_enable(kn[0]), .muxed_io_enable(kn[1]),
		.row_col_mux_enable(kn[2]), .area02_longwait_hi(kn[4]),
		.area02_longwait_lo(kn[3]), .area6_longwait_hi(kn[6]),
		.area6_longwait_lo(kn[5]), .wait_two_state(kn[14:7]),
		.decode_valid, .area_index, .space_type, .bus_width, .local_addr,
		.addr_hi_drive, .area0_select_n, .area1_select_n, .area2_select_n,
		.area3_select_n, .area4_select_n, .area5_select_n, .area6_select_n,
		.area7_select_n, .dram_strobes_active, .muxed_io_cycle,
		.sram_strobes, .longwait_states, .access_states);
	ext_device_model i_dev (.ref_clk, .rst, .select_n(sel_n),
		.strobe(sram_strobes | muxed_io_cycle), .hits);
	// ===================================================
	// clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ===================================================
	// expected decode; k = {waits, lw6, lw02, mux, ioe, dram}
	function automatic logic [47:0] exp_of(logic [27:0] a, logic [2:0] m,
		logic [14:0] k);
		space_t s;
		width_t w;
		logic [2:0] r, lw, acc;
		logic [23:0] msk;
		logic [7:0] sel;
		r = a[26:24];
		s = SPACE_EXT;
		w = a[27] ? WIDTH_16 : WIDTH_8;
		msk = 24'h3FFFFF;
		if (r == 3'h0)
			w = (m == MODE_EXT16) ? WIDTH_16 : WIDTH_8;
		if (r == 3'h0 && m == MODE_ROM)
		begin
			s = SPACE_ROM;
			w = WIDTH_32;
			msk = 24'(ROM_B - 1);
		end
		// undefined strap codes leave area 0 unanswered
		if (r == 3'h0 && m > MODE_ROM)
			s = SPACE_NONE;
		if (r == 3'h1 && k[0])
		begin
			s = SPACE_DRAM;
			msk = k[2] ? 24'hFFFFFF : msk;
		end
		if (r == 3'h5)
			w = (a[27] | a[8]) ? WIDTH_16 : WIDTH_8;
		if (r == 3'h5 && !a[27])
		begin
			s = SPACE_PERIPH;
			msk = 24'h1FF;
		end
		if (r == 3'h6)
			w = (a[27] | a[14]) ? WIDTH_16 : WIDTH_8;
		if (r == 3'h6 && !a[27] && k[1])
			s = SPACE_MUXIO;
		if (r == 3'h7)
			w = a[27] ? WIDTH_32 : WIDTH_8;
		if (r == 3'h7 && a[27])
		begin
			s = SPACE_RAM;
			msk = 24'h3FF;
		end
		sel = 8'hFF;
		lw = 3'h0;
		acc = 3'h0;
		if (s inside {SPACE_EXT, SPACE_MUXIO})
			sel[r] = 1'b0;
		if (!sel[r] && (r == 3'h0 || r == 3'h2))
			lw = 3'(k[4:3]) + 3'h1;
		if (!sel[r] && r == 3'h6)
			lw = 3'(k[6:5]) + 3'h1;
		if (s inside {SPACE_EXT, SPACE_MUXIO, SPACE_DRAM})
			acc = (lw != 3'h0) ? lw + 3'h1 : (k[7 + r] ? 3'h2 : 3'h1);
		return {s, w, sel, lw, acc, a[23:0] & msk};
	endfunction
	// ===================================================
	// checking and driving
	task automatic chk(input logic [47:0] seen, input logic [47:0] want);
		checks++;
		if (seen !== want)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic stop_test;
		if (miscompares == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// result of the previous request is checked as the next one goes in
	task automatic step(input logic [27:0] a, input logic v);
		logic [14:0] k;
		k = 15'($urandom);
		@(posedge ref_clk);
		bus_addr <= a;
		bus_addr_valid <= v;
		kn <= k;
		#1;
		if (pend)
			chk(obs & pm, pe);
		if (pend)
			chk(48'({decode_valid, area_index, addr_hi_drive}),
				48'(pa));
		if (pend && pe[37:30] != 8'hFF)
			exp_hits++;
		pend = 1'b1;
		pe = v ? exp_of(a, mode, k) : IDLE;
		pm = v ? '1 : IDLE_M;
		// upper bits only go out for muxed dram
		pa = {v, a[26:24], v && a[26:24] == 3'h1 && k[0] && k[2]};
	endtask
	// pins flipped after capture, so a live read of them shows up
	task automatic do_reset(input logic [2:0] m);
		@(posedge ref_clk);
		rst <= 1'b1;
		bus_addr_valid <= 1'b0;
		boot_mode_pins <= m;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		chk(48'({decode_valid, space_type, sel_n, access_states}),
			48'({1'b0, SPACE_NONE, SELECTS_IDLE, STATES_NONE}));
		mode = m;
		exp_hits = 0;
		pend = 1'b0;
		@(posedge ref_clk);
		boot_mode_pins <= ~m;
	endtask
	// ===================================================
	// main sequence: each boot mode, corners then random traffic
	initial
	begin
		rst = 1'b1;
		bus_addr = '0;
		bus_addr_valid = 1'b0;
		kn = '0;
		boot_mode_pins = MODE_EXT8;
		mode = MODE_EXT8;
		miscompares = 0;
		checks = 0;
		exp_hits = 0;
		pend = 1'b0;
		void'($urandom(52));
		for (int m = 0; m < 4; m++)
		begin
			do_reset(3'(m));
			for (int i = 0; i < 10; i++)
				step(CORNER[i], 1'b1);
			repeat (300) step(28'($urandom), $urandom_range(7) != 0);
			step(28'h0, 1'b0);
			@(posedge ref_clk);
			#1;
			chk(48'(hits), 48'(exp_hits));
		end
		stop_test;
	end
	// ===================================================
	// watchdog well past the ~1300 cycles the run needs
	initial
	begin
		#100000;
		miscompares++;
		stop_test;
	end
endmodule
